// ==== pcsrf_pkg.sv ====
// Package of constants and types for the clock select and reset flag block
// Function
// - External stop flag bit 7 set by hardware, cleared only by software.
// - Flag register resets to 0x48 watchdog, 0x28 software, 0x08 power-on.
// - Watchdog reset cause bit 6 is read-only, 1 after watchdog reset.
// - Software reset cause bit 5 is read-only, 1 after software reset.
// - Stop enable halts crystal once alternate clock present and selected.
// - Written crystal stop enable reads 0 until alternate clock status is 1.
// - Writing 0 to pending crystal stop enable cancels the request.
// - Divide-by-16 select bit 3 is read/write; each change raises interrupt.
// - Divide-by-16 select 0 uses crystal clock over 16, PLL off.
// - Alternate status bit 2 reads 1 only when alternate clock selected.
// - Lock flag bit 1 reads 0 while PLL off or unlocked; PLL unusable.
// - PLL select bit 0 picks crystal clock at 0, PLL output at 1.
// - PLL select clears on divider 111, xtal stop, low-power wait, div16 0.
// - Alternate clock overrides all; divide-by-16 0 overrides PLL select.
// - Multiplier bits 5:4 encode 10=14, 00=10, 11=8, 01=6.
// - Divider bits 2:0 divide by code plus one; 111 means PLL off, reset.
// - Halt without watchdog stops oscillator, holds oscillator clock high.
// - Halt with watchdog enabled leaves oscillator running.
// - Alternate select requests alternate clock, effective only if present.
// - Low-power wait turns PLL off, forces divide-by-16 or alternate clock.
package pcsrf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PCSRF_CLOCK_CONTROL_OFFSET = 8'hf0;
  localparam logic [7:0] PCSRF_CLOCK_FLAG_OFFSET = 8'hf2;
  localparam logic [7:0] PCSRF_PLL_CONFIGURATION_OFFSET = 8'hf6;
  localparam logic [7:0] PCSRF_SYSTEM_STATUS_OFFSET = 8'hf8;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCSRF_EXT_STOP_BIT = 7;
  localparam int PCSRF_WDG_CAUSE_BIT = 6;
  localparam int PCSRF_SW_CAUSE_BIT = 5;
  localparam int PCSRF_XT_STOP_BIT = 4;
  localparam int PCSRF_DIV16_BIT = 3;
  localparam int PCSRF_ALT_ST_BIT = 2;
  localparam int PCSRF_LOCK_BIT = 1;
  localparam int PCSRF_PLL_SEL_BIT = 0;
  localparam int PCSRF_ALT_SEL_BIT = 2;
  localparam int PCSRF_WAIT_SEL_BIT = 1;
  localparam int PCSRF_LP_WAIT_BIT = 0;
  localparam int PCSRF_MUL_LSB = 4;
  localparam int PCSRF_DIV_LSB = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCSRF_FLAG_RESET_WDG = 8'h48;
  localparam logic [7:0] PCSRF_FLAG_RESET_SW = 8'h28;
  localparam logic [7:0] PCSRF_FLAG_RESET_POR = 8'h08;
  localparam logic [1:0] PCSRF_MUL_RESET = 2'h0;
  localparam logic [2:0] PCSRF_DIV_RESET = 3'h7;
  localparam logic [2:0] PCSRF_DIV_PLL_OFF = 3'h7;
  localparam logic [7:0] PCSRF_CTL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PCSRF_CLK_HZ = 20000000;
  localparam int PCSRF_HALT_RESET_US = 20;
  localparam int PCSRF_HALT_RESET_CYCLES =
    (PCSRF_HALT_RESET_US * (PCSRF_CLK_HZ / 1000000));
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PCSRF_SRC_XTAL = 4'h1,
    PCSRF_SRC_DIV16 = 4'h2,
    PCSRF_SRC_PLL = 4'h4,
    PCSRF_SRC_ALT = 4'h8
  } pcsrf_source_t;

  typedef enum logic [1:0] {
    PCSRF_CAUSE_POR = 2'h0,
    PCSRF_CAUSE_WDG = 2'h1,
    PCSRF_CAUSE_SW = 2'h2
  } pcsrf_cause_t;

  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic we;
    logic sel;
    logic cyc;
    logic stb;
  } pcsrf_wb_req_t;

  typedef struct packed {
    logic [7:0] dat;
    logic ack;
  } pcsrf_wb_rsp_t;

  typedef struct packed {
    pcsrf_source_t source;
    logic crystal_run;
    logic pll_on;
    logic [3:0] pll_multiplier;
    logic [2:0] pll_divider;
    logic oscillator_clock_high;
  } pcsrf_clk_out_t;
endpackage

// ==== pcsrf_top.sv ====
// Clock selection, PLL configuration and reset-cause flag logic
`timescale 1ns/10ps
module pcsrf_top
  import pcsrf_pkg::*;
#(
  parameter int HALT_RESET_CYCLES = PCSRF_HALT_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire pcsrf_wb_req_t wb_req,
  output pcsrf_wb_rsp_t wb_rsp,
  input wire logic [1:0] reset_cause,
  input wire logic external_stop_event,
  input wire logic alternate_clock_present,
  input wire logic pll_locked_raw,
  input wire logic wait_for_interrupt,
  input wire logic halt_execute,
  input wire logic watchdog_enabled,
  input wire logic pin_reset_n,
  output pcsrf_clk_out_t clk_out,
  output logic div16_irq
);
  // Halt counter is 16 bits wide
  if (HALT_RESET_CYCLES < 1 || HALT_RESET_CYCLES > 65536) begin : g_bad_halt
    $error("HALT_RESET_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic ext_stop;
  logic wdg_cause;
  logic sw_cause;
  logic xt_stop_req;
  logic xt_stop;
  logic div16_sel;
  logic pll_sel;
  logic [1:0] mul_field;
  logic [2:0] div_field;
  logic alt_sel;
  logic wait_sel;
  logic lp_wait;
  logic [4:0] ctl_other;
  logic in_wait;
  logic halted;
  logic cause_pending;
  logic ack;
  logic [7:0] rd_data;
  logic [15:0] halt_rst_count;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire access = wb_req.cyc && wb_req.stb && !ack;
  wire wr = access && wb_req.we && wb_req.sel;
  wire hit_ctl = wb_req.adr == PCSRF_CLOCK_CONTROL_OFFSET;
  wire hit_flag = wb_req.adr == PCSRF_CLOCK_FLAG_OFFSET;
  wire hit_pll = wb_req.adr == PCSRF_PLL_CONFIGURATION_OFFSET;
  wire hit_sys = wb_req.adr == PCSRF_SYSTEM_STATUS_OFFSET;
  wire wr_ctl = wr && hit_ctl;
  wire wr_flag = wr && hit_flag;
  wire wr_pll = wr && hit_pll;
  wire [7:0] wd = wb_req.dat;

  // Low-power wait takes effect while the core idles in wait
  wire lp_active = in_wait && lp_wait;
  // Selection happens only with a live alternate clock
  wire alt_request = alt_sel || (lp_active && wait_sel);
  wire alt_status = alt_request && alternate_clock_present;
  wire halt_stops = halted;
  wire crystal_run = !xt_stop && !halt_stops;
  wire pll_on = div16_sel && !lp_active && crystal_run &&
    (div_field != PCSRF_DIV_PLL_OFF);
  wire lock_flag = pll_on && pll_locked_raw;
  wire div_off_write = wr_pll && (wd[PCSRF_DIV_LSB +: 3] ==
    PCSRF_DIV_PLL_OFF);
  wire div16_next_val = wr_flag ? wd[PCSRF_DIV16_BIT] : div16_sel;
  wire pll_sel_clear = div_off_write || !crystal_run || lp_active ||
    !div16_next_val;
  wire halt_now = halt_execute && !watchdog_enabled;

  // Clock source priority
  pcsrf_source_t next_source;
  always_comb begin
    if (alt_status) begin
      next_source = PCSRF_SRC_ALT;
    end else if (!div16_sel || lp_active) begin
      next_source = PCSRF_SRC_DIV16;
    end else if (pll_sel && lock_flag) begin
      next_source = PCSRF_SRC_PLL;
    end else begin
      next_source = PCSRF_SRC_XTAL;
    end
  end

  logic [3:0] mul_factor;
  always_comb begin
    case (mul_field)
      2'h2: mul_factor = 4'he;
      2'h0: mul_factor = 4'ha;
      2'h3: mul_factor = 4'h8;
      2'h1: mul_factor = 4'h6;
      default: mul_factor = 4'ha;
    endcase
  end

  wire [7:0] flag_read = {ext_stop, wdg_cause, sw_cause, xt_stop,
    div16_sel, alt_status, lock_flag, pll_sel};
  wire [7:0] ctl_read = {ctl_other, alt_sel, wait_sel, lp_wait};
  wire [7:0] pll_read = {2'h0, mul_field, 1'h0, div_field};
  wire [7:0] sys_read = {3'h0, halted, next_source};
  wire [7:0] next_rd = hit_flag ? flag_read :
    hit_ctl ? ctl_read :
    hit_pll ? pll_read :
    hit_sys ? sys_read : 8'h00;

  // ----------------------------------------------------------------
  // Bus slave: one-cycle ack, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
      rd_data <= 8'h00;
    end else if (ce) begin
      ack <= access;
      if (access) begin
        rd_data <= next_rd;
      end
    end
  end
  assign wb_rsp = '{dat: rd_data, ack: ack};

  // ----------------------------------------------------------------
  // Reset cause, captured by a clocked process after release
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cause_pending <= 1'b1;
      wdg_cause <= PCSRF_FLAG_RESET_POR[PCSRF_WDG_CAUSE_BIT];
      sw_cause <= PCSRF_FLAG_RESET_POR[PCSRF_SW_CAUSE_BIT];
    end else if (ce && cause_pending) begin
      cause_pending <= 1'b0;
      wdg_cause <= reset_cause == PCSRF_CAUSE_WDG;
      sw_cause <= reset_cause == PCSRF_CAUSE_SW;
    end
  end

  // ----------------------------------------------------------------
  // Flag and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_stop <= PCSRF_FLAG_RESET_POR[PCSRF_EXT_STOP_BIT];
      xt_stop_req <= 1'b0;
      xt_stop <= PCSRF_FLAG_RESET_POR[PCSRF_XT_STOP_BIT];
      div16_sel <= PCSRF_FLAG_RESET_POR[PCSRF_DIV16_BIT];
      pll_sel <= PCSRF_FLAG_RESET_POR[PCSRF_PLL_SEL_BIT];
      div16_irq <= 1'b0;
    end else if (ce) begin
      // Set wins over a software clear in the same cycle
      if (external_stop_event) begin
        ext_stop <= 1'b1;
      end else if (wr_flag && !wd[PCSRF_EXT_STOP_BIT]) begin
        ext_stop <= 1'b0;
      end
      if (wr_flag) begin
        xt_stop_req <= wd[PCSRF_XT_STOP_BIT];
        if (!wd[PCSRF_XT_STOP_BIT]) begin
          xt_stop <= 1'b0;
        end
      end else if (xt_stop_req && alt_status) begin
        xt_stop <= 1'b1;
      end
      // Leaving the alternate clock restarts the crystal
      if (xt_stop && !alt_status) begin
        xt_stop <= 1'b0;
      end
      div16_sel <= div16_next_val;
      div16_irq <= div16_next_val != div16_sel;
      if (pll_sel_clear) begin
        pll_sel <= 1'b0;
      end else if (wr_flag) begin
        pll_sel <= wd[PCSRF_PLL_SEL_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mul_field <= PCSRF_MUL_RESET;
      div_field <= PCSRF_DIV_RESET;
      alt_sel <= 1'b0;
      wait_sel <= 1'b0;
      lp_wait <= 1'b0;
      ctl_other <= PCSRF_CTL_RESET[7:3];
      in_wait <= 1'b0;
    end else if (ce) begin
      in_wait <= wait_for_interrupt;
      if (wr_pll) begin
        mul_field <= wd[PCSRF_MUL_LSB +: 2];
        div_field <= wd[PCSRF_DIV_LSB +: 3];
      end
      if (wr_ctl) begin
        alt_sel <= wd[PCSRF_ALT_SEL_BIT];
        wait_sel <= wd[PCSRF_WAIT_SEL_BIT];
        lp_wait <= wd[PCSRF_LP_WAIT_BIT];
        ctl_other <= wd[7:3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Halt: oscillator held off until a long enough pin reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      halted <= 1'b0;
      halt_rst_count <= 16'h0000;
    end else if (ce) begin
      if (halt_now) begin
        halted <= 1'b1;
      end else if (halted) begin
        if (pin_reset_n) begin
          halt_rst_count <= 16'h0000;
        end else if (halt_rst_count >= 16'(HALT_RESET_CYCLES - 1)) begin
          halted <= 1'b0;
          halt_rst_count <= 16'h0000;
        end else begin
          halt_rst_count <= halt_rst_count + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_out <= '{source: PCSRF_SRC_XTAL, crystal_run: 1'b1,
        pll_on: 1'b0, pll_multiplier: 4'ha, pll_divider: PCSRF_DIV_RESET,
        oscillator_clock_high: 1'b0};
    end else if (ce) begin
      clk_out.source <= next_source;
      clk_out.crystal_run <= crystal_run;
      clk_out.pll_on <= pll_on;
      clk_out.pll_multiplier <= mul_factor;
      clk_out.pll_divider <= div_field;
      clk_out.oscillator_clock_high <= halt_stops;
    end
  end
endmodule // pcsrf_top

// ==== pcsrf_assertions.sv ====
// Assertion checker for the clock select and reset flag block
`timescale 1ns/10ps
module pcsrf_assertions
  import pcsrf_pkg::*;
#(
  parameter int HALT_RESET_CYCLES = PCSRF_HALT_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire pcsrf_wb_rsp_t wb_rsp,
  input wire logic alternate_clock_present,
  input wire logic halt_execute,
  input wire logic watchdog_enabled,
  input wire logic pin_reset_n,
  input wire pcsrf_clk_out_t clk_out,
  input wire logic div16_irq
);
  logic [15:0] low_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Saturates so a long pin reset cannot wrap
  always_ff @(posedge clk) begin
    if (srst || pin_reset_n) begin
      low_n <= 16'h0000;
    end else if (low_n != 16'hffff) begin
      low_n <= low_n + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_div16_pll_off: assert property (
    clk_out.source == PCSRF_SRC_DIV16 |-> !clk_out.pll_on)
    else $error("pll on with div16 source");
  a_pll_src_on: assert property (
    clk_out.source == PCSRF_SRC_PLL |-> clk_out.pll_on)
    else $error("pll source while pll off");
  a_alt_needs_clock: assert property (
    !alternate_clock_present [*3] |=> clk_out.source != PCSRF_SRC_ALT)
    else $error("alt source without clock");
  a_mult_legal: assert property (
    clk_out.pll_multiplier inside {4'd14, 4'd10, 4'd8, 4'd6})
    else $error("illegal multiplier");
  a_div7_no_pll: assert property (
    clk_out.pll_divider == 3'h7 [*2] |-> clk_out.source != PCSRF_SRC_PLL)
    else $error("pll used with divider 7");
  a_source_onehot: assert property ($onehot(clk_out.source))
    else $error("source not one-hot");
  a_irq_pulse: assert property (div16_irq |=> !div16_irq)
    else $error("irq longer than one cycle");
  a_halt_osc_high: assert property (
    halt_execute && !watchdog_enabled |-> ##[1:3]
    clk_out.oscillator_clock_high)
    else $error("halt did not stop oscillator");
  a_wdg_keeps_osc: assert property (
    halt_execute && watchdog_enabled && !clk_out.oscillator_clock_high
    |=> !clk_out.oscillator_clock_high [*2])
    else $error("halt stopped oscillator with watchdog");
  a_halt_exit: assert property (
    low_n > HALT_RESET_CYCLES + 2 |-> !clk_out.oscillator_clock_high)
    else $error("oscillator not restarted by pin reset");
  cover property (wb_rsp.ack);
  cover property (clk_out.source == PCSRF_SRC_PLL);
  cover property (clk_out.source == PCSRF_SRC_ALT);
endmodule // pcsrf_assertions

// ==== pcsrf_top_tb.sv ====
// Self-checking testbench for the clock select and reset flag block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pcsrf_top_tb
  import pcsrf_pkg::*;
;
  localparam logic [7:0] FLG = PCSRF_CLOCK_FLAG_OFFSET;
  localparam logic [7:0] PLL = PCSRF_PLL_CONFIGURATION_OFFSET;
  localparam logic [7:0] CTL = PCSRF_CLOCK_CONTROL_OFFSET;
  logic clk, srst, ce, external_stop_event, alternate_clock_present;
  logic pll_locked_raw, wait_for_interrupt, halt_execute;
  logic watchdog_enabled, pin_reset_n, div16_irq;
  logic [1:0] reset_cause;
  logic [7:0] q;
  pcsrf_wb_req_t wb_req;
  pcsrf_wb_rsp_t wb_rsp;
  pcsrf_clk_out_t clk_out;
  int fail_count, n_tests, irq_n;
  pcsrf_top #(.HALT_RESET_CYCLES(4)) pcsrf_top_i (.clk, .srst, .ce, .wb_req,
    .wb_rsp, .reset_cause, .external_stop_event, .alternate_clock_present,
    .pll_locked_raw, .wait_for_interrupt, .halt_execute, .watchdog_enabled,
    .pin_reset_n, .clk_out, .div16_irq);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (div16_irq === 1'b1) irq_n++;
  // ------------------------------------------------------------
  // Bus and helpers
  // ------------------------------------------------------------
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    wb_req <= '{adr: a, dat: d, we: w, sel: 1'b1, cyc: 1'b1, stb: 1'b1};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
    wb(a, 1'b0, 8'h00);
    `CHK(s, e, q)
  endtask
  task automatic wt();
    repeat (4) @(posedge clk);
  endtask
  task automatic rst(input logic [1:0] c);
    reset_cause <= c;
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic halt(input logic w);
    watchdog_enabled <= w;
    halt_execute <= 1'b1;
    @(posedge clk);
    halt_execute <= 1'b0;
    wt();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [1:0] c [3] = '{2'h1, 2'h2, 2'h0};
    logic [7:0] e [3] = '{8'h48, 8'h28, 8'h08};
    for (int i = 0; i < 3; i++) begin
      rst(c[i]);
      rd(FLG, e[i], "flag rst");
      wb(FLG, 1'b1, 8'h6e);
      rd(FLG, e[i], "flag ro");
    end
    rd(PLL, 8'h07, "pll rst");
    rd(8'haa, 8'h00, "unmapped");
    `CHK("src", PCSRF_SRC_XTAL, clk_out.source)
    external_stop_event <= 1'b1;
    @(posedge clk);
    external_stop_event <= 1'b0;
    rd(FLG, 8'h88, "stop set");
    rd(FLG, 8'h88, "stop kept");
    wb(FLG, 1'b1, 8'h08);
    rd(FLG, 8'h08, "stop clr");
    $display("t_reset done");
  endtask
  task automatic t_div16();
    int n0;
    n0 = irq_n;
    wb(FLG, 1'b1, 8'h00);
    wt();
    `CHK("irq", n0 + 1, irq_n)
    `CHK("src", PCSRF_SRC_DIV16, clk_out.source)
    `CHK("pll", 1'b0, clk_out.pll_on)
    wb(FLG, 1'b1, 8'h08);
    wb(FLG, 1'b1, 8'h08);
    wt();
    `CHK("irq", n0 + 2, irq_n)
    // Enable low must swallow a stop event
    ce <= 1'b0;
    external_stop_event <= 1'b1;
    @(posedge clk);
    external_stop_event <= 1'b0;
    ce <= 1'b1;
    rd(FLG, 8'h08, "ce hold");
    $display("t_div16 done");
  endtask
  task automatic t_pll();
    logic [3:0] f [4] = '{4'd10, 4'd6, 4'd14, 4'd8};
    for (int i = 0; i < 4; i++) begin
      wb(PLL, 1'b1, {2'b00, 2'(i), 4'h1});
      wt();
      `CHK("mul", f[i], clk_out.pll_multiplier)
      `CHK("div", 3'h1, clk_out.pll_divider)
    end
    wb(FLG, 1'b1, 8'h09);
    wt();
    `CHK("unlocked", PCSRF_SRC_XTAL, clk_out.source)
    pll_locked_raw <= 1'b1;
    wb(FLG, 1'b1, 8'h09);
    rd(FLG, 8'h0b, "lock");
    `CHK("pll src", PCSRF_SRC_PLL, clk_out.source)
    wb(FLG, 1'b1, 8'h01);
    rd(FLG, 8'h00, "div16 clr");
    wb(FLG, 1'b1, 8'h09);
    wb(PLL, 1'b1, 8'h37);
    rd(FLG, 8'h08, "div7 clr");
    wb(PLL, 1'b1, 8'h31);
    wb(FLG, 1'b1, 8'h09);
    wb(CTL, 1'b1, 8'h01);
    wait_for_interrupt <= 1'b1;
    wt();
    `CHK("lp src", PCSRF_SRC_DIV16, clk_out.source)
    `CHK("lp pll", 1'b0, clk_out.pll_on)
    wait_for_interrupt <= 1'b0;
    rd(FLG, 8'h0a, "lp clr");
    wb(CTL, 1'b1, 8'h00);
    pll_locked_raw <= 1'b0;
    wb(PLL, 1'b1, 8'h07);
    $display("t_pll done");
  endtask
  task automatic t_alt();
    alternate_clock_present <= 1'b0;
    wb(CTL, 1'b1, 8'h04);
    wb(FLG, 1'b1, 8'h18);
    rd(FLG, 8'h08, "xt pend");
    wb(FLG, 1'b1, 8'h08);
    alternate_clock_present <= 1'b1;
    wt();
    rd(FLG, 8'h0c, "alt st");
    `CHK("alt src", PCSRF_SRC_ALT, clk_out.source)
    `CHK("xt run", 1'b1, clk_out.crystal_run)
    wb(FLG, 1'b1, 8'h18);
    rd(FLG, 8'h1c, "xt stop");
    `CHK("xt off", 1'b0, clk_out.crystal_run)
    wb(CTL, 1'b1, 8'h00);
    alternate_clock_present <= 1'b0;
    wt();
    `CHK("xt back", 1'b1, clk_out.crystal_run)
    wb(CTL, 1'b1, 8'h03);
    alternate_clock_present <= 1'b1;
    wait_for_interrupt <= 1'b1;
    wt();
    `CHK("wfi alt", PCSRF_SRC_ALT, clk_out.source)
    `CHK("wfi xt", 1'b0, clk_out.crystal_run)
    wait_for_interrupt <= 1'b0;
    wb(FLG, 1'b1, 8'h08);
    wb(CTL, 1'b1, 8'h00);
    alternate_clock_present <= 1'b0;
    wt();
    $display("t_alt done");
  endtask
  task automatic t_halt();
    halt(1'b1);
    `CHK("osc wdg", 1'b0, clk_out.oscillator_clock_high)
    halt(1'b0);
    `CHK("osc halt", 1'b1, clk_out.oscillator_clock_high)
    rd(PCSRF_SYSTEM_STATUS_OFFSET, 8'h11, "sys halt");
    pin_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_reset_n <= 1'b1;
    wt();
    `CHK("osc exit", 1'b0, clk_out.oscillator_clock_high)
    $display("t_halt done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {ce, pin_reset_n} = 2'b11;
    {external_stop_event, alternate_clock_present, pll_locked_raw} = 3'h0;
    {wait_for_interrupt, halt_execute, watchdog_enabled} = 3'h0;
    wb_req = '0;
    t_reset();
    t_div16();
    t_pll();
    t_alt();
    t_halt();
    stop_test();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule // pcsrf_top_tb
bind pcsrf_top pcsrf_assertions #(.HALT_RESET_CYCLES(HALT_RESET_CYCLES))
  pcsrf_assertions_i (.clk, .srst, .wb_rsp, .alternate_clock_present,
  .halt_execute, .watchdog_enabled, .pin_reset_n, .clk_out, .div16_irq);
